// >>> design/tsc_clock_ctrl.sv
// Purpose: Two-speed two-phase processor clock, periodic interrupt, watchdog.
// Assumes: All inputs except nrst_i, which has its own synchronizer, are synchronous to clk_sys_i.
// Notes: The 4 MHz oscillator is an enable pulse from a divider.
`default_nettype none
module tsc_clock_ctrl #(
   parameter int TB_STAGES = tsc_pkg::TB_STAGES,
   parameter int WD_BITS = tsc_pkg::WD_BITS
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic power_on_reset_i,
   input wire logic [tsc_pkg::ADDR_W-1:0] addr_i,
   input wire logic read_not_write_i,
   input wire logic valid_address_strobe_i,
   output logic phi1_o,
   output logic phi2_o,
   output logic rate_select_o,
   output logic interrupt_request_n_o,
   output logic interrupt_ack_strobe_o,
   output logic watchdog_clear_n_o,
   output logic cpu_reset_n_o
);
   logic rst_meta;
   logic rst_n;
   logic [4:0] osc_cnt;
   logic osc_tick;
   logic half;
   logic tap_tick;
   logic [3:0] div_cnt;
   logic [3:0] next_div_cnt;
   logic [3:0] start_cur;
   logic rate_cur;
   logic preload;
   logic started;
   logic [TB_STAGES-1:0] tb_cnt;
   logic tb_wrap;
   logic [WD_BITS-1:0] wd_cnt;
   logic wd_full;
   logic ack_hit;
   logic clr_hit;

   function automatic logic addr_hit(input logic [15:0] a,
                                     input logic [15:0] ref_addr);
      addr_hit = (a & tsc_pkg::DECODE_MASK) ==
                 (ref_addr & tsc_pkg::DECODE_MASK);
   endfunction

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // The oscillator stand-in: one enable pulse every 25 system cycles.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         osc_cnt <= 5'h00;
      end else if (osc_tick) begin
         osc_cnt <= 5'h00;
      end else begin
         osc_cnt <= osc_cnt + 5'h01;
      end
   end
   assign osc_tick = osc_cnt == tsc_pkg::OSC_LAST;

   // Half rate of the oscillator is a constant 2 MHz, whatever the speed.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         half <= 1'b0;
      end else if (osc_tick) begin
         half <= !half;
      end
   end
   assign tap_tick = osc_tick && half;

   assign preload = div_cnt == tsc_pkg::DIV_LAST;
   assign start_cur = rate_cur ? tsc_pkg::DIV_START_FAST
                               : tsc_pkg::DIV_START_SLOW;

   always_comb begin
      if (preload) begin
         next_div_cnt = addr_i[tsc_pkg::RATE_BIT] ?
                        tsc_pkg::DIV_START_FAST : tsc_pkg::DIV_START_SLOW;
      end else begin
         next_div_cnt = div_cnt + 4'h1;
      end
   end

   // Rate is sampled only on preload, so a phase is never cut short.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= tsc_pkg::DIV_LAST;
         rate_cur <= 1'b0;
         started <= 1'b0;
      end else if (osc_tick) begin
         div_cnt <= next_div_cnt;
         started <= 1'b1;
         if (preload) begin
            rate_cur <= addr_i[tsc_pkg::RATE_BIT];
         end
      end
   end

   // Phase one covers the first two counts of a cycle, phase two the rest.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         phi1_o <= 1'b0;
         phi2_o <= 1'b0;
      end else if (osc_tick) begin
         if (preload) begin
            phi1_o <= 1'b1;
            phi2_o <= 1'b0;
         end else begin
            phi1_o <= (next_div_cnt - start_cur) < tsc_pkg::PHI1_COUNTS;
            phi2_o <= (next_div_cnt - start_cur) >=
                      tsc_pkg::PHI1_COUNTS;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         rate_select_o <= 1'b0;
      end else begin
         rate_select_o <= addr_i[tsc_pkg::RATE_BIT];
      end
   end

   // Twelve binary stages of the 2 MHz tap.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         tb_cnt <= '0;
      end else if (tap_tick) begin
         tb_cnt <= tb_cnt + 1'b1;
      end
   end
   assign tb_wrap = tap_tick && (&tb_cnt);

   assign ack_hit = valid_address_strobe_i && phi2_o && !read_not_write_i &&
                    addr_hit(addr_i, tsc_pkg::IRQ_ACK_ADDR);
   assign clr_hit = valid_address_strobe_i && phi2_o && !read_not_write_i &&
                    addr_hit(addr_i, tsc_pkg::WDOG_CLEAR_ADDR);
   assign interrupt_ack_strobe_o = ack_hit;
   assign watchdog_clear_n_o = !clr_hit;

   // A timebase event in the acknowledge cycle wins, so no interrupt is lost.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_request_n_o <= 1'b1;
      end else if (!cpu_reset_n_o) begin
         interrupt_request_n_o <= 1'b1;
      end else if (tb_wrap) begin
         interrupt_request_n_o <= 1'b0;
      end else if (ack_hit) begin
         interrupt_request_n_o <= 1'b1;
      end
   end

   // Watchdog reset lasts one interrupt period, then the count wraps to zero.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt <= '0;
      end else if (power_on_reset_i) begin
         wd_cnt <= '0;
      end else if (tb_wrap) begin
         wd_cnt <= clr_hit ? WD_BITS'(1) : wd_cnt + 1'b1;
      end else if (clr_hit) begin
         wd_cnt <= '0;
      end
   end
   assign wd_full = &wd_cnt;

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         cpu_reset_n_o <= 1'b0;
      end else begin
         cpu_reset_n_o <= !(power_on_reset_i || wd_full);
      end
   end

   logic [7:0] hi1_len;
   logic [7:0] hi2_len;
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         hi1_len <= 8'h00;
         hi2_len <= 8'h00;
      end else begin
         hi1_len <= phi1_o ? hi1_len + 8'h01 : 8'h00;
         hi2_len <= phi2_o ? hi2_len + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   phases_opposite_a: assert property (started |-> phi1_o != phi2_o)
      else $error("Clock phases overlap or are both low.");
   rate_follow_a: assert property (##1 rate_select_o ==
      $past(addr_i[tsc_pkg::RATE_BIT]))
      else $error("Rate select does not follow address bit 13.");
   div_range_a: assert property (started |->
      div_cnt >= start_cur && div_cnt <= tsc_pkg::DIV_LAST)
      else $error("Divider count out of range.");
   phi1_width_a: assert property ($fell(phi1_o) |->
      hi1_len == 8'(tsc_pkg::PHASE_SHORT_CYC))
      else $error("Phase one high width wrong.");
   phi2_width_a: assert property ($fell(phi2_o) |-> hi2_len ==
      ($past(rate_cur) ? 8'(tsc_pkg::PHASE_SHORT_CYC)
                       : 8'(tsc_pkg::PHASE_LONG_CYC)))
      else $error("Phase two high width wrong.");
   irq_set_a: assert property (tb_wrap && cpu_reset_n_o |=>
      !interrupt_request_n_o)
      else $error("Interrupt request not raised.");
   irq_ack_a: assert property (ack_hit && !tb_wrap |=>
      interrupt_request_n_o)
      else $error("Acknowledge did not clear interrupt.");
   irq_reset_a: assert property (!cpu_reset_n_o |=>
      interrupt_request_n_o)
      else $error("Reset did not clear interrupt.");
   // Processor reset is a register, so it follows power reset one edge on.
   reset_src_a: assert property (power_on_reset_i |=> !cpu_reset_n_o)
      else $error("Power reset did not reach processor reset.");
   wd_step_a: assert property (wd_cnt != $past(wd_cnt) |->
      $past(tb_wrap || clr_hit || power_on_reset_i))
      else $error("Watchdog moved without a cause.");
   wd_clear_a: assert property (clr_hit && !tb_wrap |=> wd_cnt == '0)
      else $error("Watchdog clear failed.");
   wd_fire_a: assert property (wd_full |=> !cpu_reset_n_o)
      else $error("Watchdog full without reset.");
   strobe_gate_a: assert property ((interrupt_ack_strobe_o ||
      !watchdog_clear_n_o) |-> valid_address_strobe_i && phi2_o)
      else $error("Strobe outside valid phase two.");
   rate_hold_a: assert property (!$stable(rate_cur) |->
      $past(preload && osc_tick))
      else $error("Rate changed mid cycle.");

   fast_cycle_c: cover property ($rose(phi1_o) && rate_cur);
   slow_cycle_c: cover property ($rose(phi1_o) && !rate_cur);
   irq_ack_c: cover property (!interrupt_request_n_o ##1 ack_hit);
   wd_fire_c: cover property ($fell(cpu_reset_n_o) && wd_full);
endmodule
`default_nettype wire

// >>> design/tsc_pkg.sv
// Purpose: Shared constants of the two-speed processor clock block.
// Assumes: System clock of 100 MHz; processor address bus of 16 bits.
// Notes: Timing figures are kept in their own unit and turned into cycles.
`default_nettype none
package tsc_pkg;
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 4_000_000;
   localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
   localparam int PHASE_SHORT_NS = 500;
   localparam int PHASE_LONG_NS = 1000;
   localparam int PHASE_SHORT_CYC = PHASE_SHORT_NS * (SYS_CLK_HZ / 1_000_000)
                                    / 1000;
   localparam int PHASE_LONG_CYC = PHASE_LONG_NS * (SYS_CLK_HZ / 1_000_000)
                                   / 1000;
   localparam logic [4:0] OSC_LAST = 5'(OSC_DIV - 1);
   localparam logic [3:0] DIV_START_SLOW = 4'h4;
   localparam logic [3:0] DIV_START_FAST = 4'h6;
   localparam logic [3:0] DIV_LAST = 4'h9;
   localparam logic [3:0] PHI1_COUNTS = 4'h2;
   localparam int ADDR_W = 16;
   localparam int RATE_BIT = 13;
   localparam logic [15:0] DECODE_MASK = 16'h38E0;
   localparam logic [15:0] WDOG_CLEAR_ADDR = 16'h18C0;
   localparam logic [15:0] IRQ_ACK_ADDR = 16'h18E0;
   localparam int TB_STAGES = 12;
   localparam int WD_BITS = 4;
endpackage
`default_nettype wire

// >>> dv/tsc_cpu_model.sv
// Purpose: Processor bus model that presents one access per clock cycle.
// Assumes: A new access starts at the first edge after phase one rises.
// Notes: Acknowledge beats watchdog clear, which beats the bench request.
`default_nettype none
module tsc_cpu_model (
   input wire logic clk_i,
   input wire logic phi1_i,
   input wire logic irq_n_i,
   input wire logic auto_ack_i,
   input wire logic auto_clear_i,
   input wire logic [15:0] req_addr_i,
   input wire logic req_rnw_i,
   input wire logic req_vma_i,
   output logic [15:0] addr_o,
   output logic rnw_o,
   output logic vma_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic phi1_q;
   initial begin
      phi1_q = 1'b0;
      addr_o = 16'h0000;
      rnw_o = 1'b1;
      vma_o = 1'b0;
   end
   // The access is held for the whole cycle, so the address is stable
   // well before phase two opens the decoder.
   always @(posedge clk_i) begin
      phi1_q <= phi1_i;
      if (phi1_i && !phi1_q) begin
         if (auto_ack_i && !irq_n_i) begin
            {addr_o, rnw_o, vma_o} <= {16'h18E0, 2'h1};
         end else if (auto_clear_i) begin
            {addr_o, rnw_o, vma_o} <= {16'h18C0, 2'h1};
         end else begin
            {addr_o, rnw_o, vma_o} <= {req_addr_i, req_rnw_i, req_vma_i};
         end
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the two-speed clock block.
// Assumes: Short timebase and watchdog keep each scenario brief.
// Notes: The processor model owns the bus; the bench steers it.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TBS = 3;
   localparam int WDB = 2;
   localparam int PERIOD = (1 << TBS) * 50;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic por = 1'b0;
   logic auto_ack = 1'b0;
   logic auto_clear = 1'b0;
   logic [15:0] req_addr = 16'h2000;
   logic req_rnw = 1'b1;
   logic req_vma = 1'b1;
   logic [15:0] addr;
   logic rnw, valid_address_strobe, phi1, phi2, rate, irq_n, ack, clr_n, cpu_rst_n;
   int err_count = 0;
   int checks = 0;
   int n;
   int n1;
   tsc_clock_ctrl #(.TB_STAGES(TBS), .WD_BITS(WDB)) i_tsc_clock_ctrl (
      .clk_sys_i(clk_sys), .nrst_i(nrst), .power_on_reset_i(por),
      .addr_i(addr), .read_not_write_i(rnw), .valid_address_strobe_i(valid_address_strobe),
      .phi1_o(phi1), .phi2_o(phi2), .rate_select_o(rate),
      .interrupt_request_n_o(irq_n), .interrupt_ack_strobe_o(ack),
      .watchdog_clear_n_o(clr_n), .cpu_reset_n_o(cpu_rst_n));
   tsc_cpu_model i_tsc_cpu_model (
      .clk_i(clk_sys), .phi1_i(phi1), .irq_n_i(irq_n),
      .auto_ack_i(auto_ack), .auto_clear_i(auto_clear),
      .req_addr_i(req_addr), .req_rnw_i(req_rnw), .req_vma_i(req_vma),
      .addr_o(addr), .rnw_o(rnw), .vma_o(valid_address_strobe));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Counts falling edges until the chosen output reaches the level.
   task automatic wait_sig(input int sel, input logic lvl);
      logic cur;
      n = 0;
      while (n < 5000) begin
         @(negedge clk_sys);
         cur = sel == 0 ? phi1 : sel == 1 ? phi2 : sel == 2 ? irq_n : cpu_rst_n;
         if (cur === lvl) break;
         n++;
      end
      check(16'(n < 5000), 16'h0001);
   endtask
   task automatic phase_test(input logic [15:0] a, input logic rw,
                             input logic [15:0] hi2);
      req_addr = a;
      req_rnw = rw;
      repeat (2) begin
         wait_sig(1, 1'b0);
         wait_sig(1, 1'b1);
      end
      check(16'(rate), 16'(a[13]));
      wait_sig(1, 1'b0);
      check(16'(n + 1), hi2);
      wait_sig(0, 1'b0);
      check(16'(n + 1), 16'h0032);
   endtask
   task automatic strobe_test(input logic [15:0] a, input logic rw,
                              input logic v, input logic ea, input logic ec);
      req_addr = a;
      req_rnw = rw;
      req_vma = v;
      wait_sig(0, 1'b0);
      wait_sig(0, 1'b1);
      @(negedge clk_sys);
      check(16'({ack, clr_n}), 16'h0001);
      wait_sig(1, 1'b1);
      check(16'({ack, clr_n}), 16'({ea, !ec}));
   endtask
   // Interrupt held without acknowledge, then acknowledged every period.
   task automatic irq_test();
      auto_clear = 1'b1;
      wait_sig(2, 1'b0);
      repeat (200) @(negedge clk_sys);
      check(16'(irq_n), 16'h0000);
      auto_ack = 1'b1;
      wait_sig(2, 1'b1);
      wait_sig(2, 1'b0);
      wait_sig(2, 1'b1);
      n1 = n;
      wait_sig(2, 1'b0);
      check(16'(n1 + n + 2), 16'(PERIOD));
   endtask
   // Clears keep the processor running; without them the watchdog fires.
   task automatic watchdog_test();
      auto_clear = 1'b1;
      auto_ack = 1'b1;
      repeat (4 * PERIOD) @(negedge clk_sys);
      check(16'(cpu_rst_n), 16'h0001);
      auto_clear = 1'b0;
      req_vma = 1'b0;
      wait_sig(3, 1'b0);
      check(16'(n > PERIOD && n < (1 << WDB) * PERIOD), 16'h0001);
      repeat (2) @(negedge clk_sys);
      check(16'(irq_n), 16'h0001);
      wait_sig(3, 1'b1);
      check(16'(n < PERIOD + 2), 16'h0001);
   endtask
   // Power reset while an interrupt is pending.
   task automatic power_reset_test();
      auto_clear = 1'b1;
      auto_ack = 1'b0;
      wait_sig(2, 1'b0);
      por = 1'b1;
      wait_sig(3, 1'b0);
      check(16'(n < 3), 16'h0001);
      repeat (2) @(negedge clk_sys);
      check(16'(irq_n), 16'h0001);
      por = 1'b0;
      wait_sig(3, 1'b1);
      check(16'(n < 3), 16'h0001);
   endtask
   initial begin
      repeat (2) @(negedge clk_sys);
      check(16'({irq_n, cpu_rst_n}), 16'h0002);
      nrst = 1'b1;
      phase_test(16'h2000, 1'b1, 16'h0032);
      phase_test(16'h18C0, 1'b0, 16'h0064);
      strobe_test(16'h18E0, 1'b0, 1'b1, 1'b1, 1'b0);
      strobe_test(16'h18E0, 1'b1, 1'b1, 1'b0, 1'b0);
      strobe_test(16'h18C0, 1'b0, 1'b1, 1'b0, 1'b1);
      strobe_test(16'h18E0, 1'b0, 1'b0, 1'b0, 1'b0);
      strobe_test(16'h38E0, 1'b0, 1'b1, 1'b0, 1'b0);
      irq_test();
      watchdog_test();
      power_reset_test();
      complete_run();
   end
   always @(negedge clk_sys) begin
      if (phi1 === 1'b1 && phi2 === 1'b1) check(16'h0001, 16'h0000);
   end
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
